// ---- hdl/pdi_access_consts.svh ----
// Purpose: Offsets, field positions, reset values and codes of the debug access block.
// Assumes: Included by its bare name in the access block and its bench; the monitor writes its figures as literals.
// Notes: Definitions only.
`ifndef PDI_ACCESS_CONSTS_SVH
`define PDI_ACCESS_CONSTS_SVH
// ***************************************************************
// Register offsets
// ***************************************************************
`define PDI_OFS_REV 4'h0
`define PDI_OFS_ERR 4'h1
`define PDI_OFS_CTRLP 4'h2
`define PDI_OFS_CTRLS 4'h3
`define PDI_OFS_ASI_LO 4'h4
`define PDI_OFS_ASI_HI 4'hC
`define PDI_OFS_KEY 4'h7
`define PDI_OFS_RST 4'h8
`define PDI_OFS_CLKSEL 4'h9
`define PDI_OFS_SYSCTL 4'hA
`define PDI_OFS_SYSSTAT 4'hB
`define PDI_OFS_SCAN 4'hC
// ***************************************************************
// Field positions
// ***************************************************************
`define PDI_BIT_KEY_UROW 5
`define PDI_BIT_KEY_NVM 4
`define PDI_BIT_KEY_ERASE 3
`define PDI_BIT_CTL_KEEPCLK 0
`define PDI_BIT_CTL_UROWDONE 1
`define PDI_BIT_ST_RESET 5
`define PDI_BIT_ST_SLEEP 4
`define PDI_BIT_ST_NVM 3
`define PDI_BIT_ST_UROW 2
`define PDI_BIT_ST_LOCK 0
`define PDI_BIT_DISABLE 2
// ***************************************************************
// Values, masks and resets
// ***************************************************************
`define PDI_RST_SIGNATURE 8'h59
`define PDI_RST_REV 8'h10
`define PDI_RST_CLKSEL 2'h2
`define PDI_RST_KEEPCLK 1'b1
`define PDI_MASK_CTRLP 8'hBF
`define PDI_MASK_CTRLS 8'h1C
`define PDI_BOD_ACTIVE_ON 2'h1
`define PDI_BOD_ACTIVE_OFF 2'h0
`define PDI_UROW_BYTES 32
`endif

// ---- hdl/pdi_pkg.sv ----
// Purpose: Types shared by the debug access block and its row buffer.
// Assumes: Constants live in pdi_access_consts.svh.
// Notes: Nothing here is imported; users write pdi_pkg::name.
package pdi_pkg;
  // Key delivered by the frame layer after a signature matched.
  typedef enum logic [1:0] {PDI_KEY_ERASE, PDI_KEY_NVM, PDI_KEY_UROW, PDI_KEY_NONE} pdi_key_t;
  // Control-space request from the physical layer.
  typedef struct packed {
    logic we;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pdi_cs_req_t;
  // Memory request on the debugger path or the system bus.
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pdi_bus_req_t;
  // Whole state of the access block.
  typedef struct packed {
    logic cs_ack;
    logic [7:0] cs_rdata;
    logic [2:0] err;
    logic [7:0] ctrl_p;
    logic [7:0] ctrl_s;
    logic [1:0] clk_sel;
    logic [7:0] rst_req;
    logic key_erase;
    logic key_nvm;
    logic key_urow;
    logic keep_clk;
    logic erase_run;
    logic erase_start;
    logic [1:0] bod_mode;
    logic [2:0] bod_level;
    logic nvm_state;
    logic urow_state;
    logic lock;
    logic sleep_s1;
    logic sleep_s2;
    logic stop_s1;
    logic stop_s2;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic sync_evt;
    logic bus_wait;
    logic sys_req;
    pdi_bus_req_t sys_bus;
    logic dbg_done;
    logic dbg_refused;
    logic [7:0] dbg_rdata;
    logic copy_run;
    logic [5:0] copy_idx;
    logic copy_pend;
    logic [4:0] copy_pidx;
    logic row_wr_en;
    logic [4:0] row_addr;
    logic [7:0] row_data;
  } pdi_state_t;
  // State of the row buffer read port.
  typedef struct packed {
    logic [7:0] rdata;
  } pdi_buf_state_t;
endpackage

// ---- hdl/pdi_urow_buffer.sv ----
// Purpose: Byte buffer that holds configuration row data until the copy.
// Assumes: One write and one read port on ref_clk; read data one cycle later.
// Notes: Contents are not cleared by reset; only written bytes are meaningful.
`timescale 1ns/100ps
`default_nettype none
module pdi_urow_buffer #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // ***************************************************************
  // Storage
  // ***************************************************************
  logic [7:0] mem [DEPTH];
  pdi_pkg::pdi_buf_state_t st_reg;
  pdi_pkg::pdi_buf_state_t st_next;

  // The address width must reach every entry exactly.
  if (DEPTH != (1 << AW))
    $error("pdi_urow_buffer: DEPTH must equal 2**AW");

  // Memory writes stay out of the reset so the array maps to plain storage.
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port.
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = mem[rd_addr];
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rdata;
endmodule
`default_nettype wire

// ---- hdl/pdi_access.sv ----
// Purpose: Access layer of the program and debug interface: keys, system reset, status, row buffer.
// Assumes: Physical layer on ref_clk hands over control-space requests and decoded keys.
// Notes: No on-chip CPU port exists; only the link side reaches these registers.
`timescale 1ns/100ps
`default_nettype none
`include "pdi_access_consts.svh"
// How it works
// - Lock flag reads 1 until erase completes, then 0 with full access.
// - While locked, system bus access is refused; control space still works.
// - During erase the brownout detector is forced on, mode 0x1, fuse level.
// - In user-row mode only writes to the first 32 bytes are executed.
// - On completion buffered bytes copy one to one into the config row.
// - Write-done bit starts the copy; user-row state clears when it ends.
// - In user-row mode memory reads return no data.
// - Every rising edge inside the sync character emits an event pulse.
// - Link side keeps running in every sleep mode while enabled.
// - With the CPU clock stopped and keep-clock clear, memory accesses outside user-row mode are refused.
// - Asleep flag follows the system domain idle-or-deeper sleep level.
// - Keep-clock request holds the system clock so bus access still works.
// - Keep-clock request resets to 1.
// - Registers are reached only through link control-space requests.
// - Offsets 0x0-0x3 are link configuration, 0x4-0xC access registers.
// - Writing 0x59 to the reset request asserts system reset, not ours.
// - Any other value releases it; bit 0 reads the held reset.
module pdi_access #(
  parameter logic [7:0] REVISION = `PDI_RST_REV,
  parameter int UROW_BYTES = `PDI_UROW_BYTES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_valid,
  input wire pdi_pkg::pdi_cs_req_t cs_req,
  output logic cs_ack,
  output logic [7:0] cs_rdata,
  input wire logic key_valid,
  input wire pdi_pkg::pdi_key_t key_kind,
  input wire logic phy_err_valid,
  input wire logic [2:0] phy_err_code,
  output logic [7:0] phy_ctrl_primary,
  output logic [7:0] phy_ctrl_secondary,
  output logic [1:0] access_clk_sel,
  input wire logic link_rx_pin,
  input wire logic sync_window,
  output logic sync_edge_event,
  input wire logic sys_sleep_async,
  input wire logic cpu_clk_stopped_async,
  input wire logic lockbits_set,
  input wire logic erase_done,
  input wire logic [2:0] scan_status,
  input wire logic [2:0] bod_fuse_level,
  output logic sys_reset_out,
  output logic erase_start,
  output logic bod_force_on,
  output logic [1:0] bod_active_mode,
  output logic [2:0] bod_level,
  output logic keep_clock_out,
  input wire logic dbg_valid,
  input wire pdi_pkg::pdi_bus_req_t dbg_req,
  output logic dbg_done,
  output logic dbg_refused,
  output logic [7:0] dbg_rdata,
  output logic sys_req,
  output pdi_pkg::pdi_bus_req_t sys_bus,
  input wire logic sys_ack,
  input wire logic [7:0] sys_rdata,
  output logic row_wr_en,
  output logic [4:0] row_addr,
  output logic [7:0] row_data
);
  // ***************************************************************
  // State and helpers
  // ***************************************************************
  pdi_pkg::pdi_state_t st_reg;
  pdi_pkg::pdi_state_t st_next;
  logic buf_we;
  logic [7:0] buf_rdata;
  logic cs_wr;
  logic cs_rd;
  logic rst_release;
  logic [7:0] rd_mux;

  // The copy walks a 5-bit index; other sizes would need wider ports.
  if (UROW_BYTES != 32)
    $error("pdi_access: UROW_BYTES must be 32");

  pdi_urow_buffer #(
    .DEPTH(UROW_BYTES),
    .AW(5)
  ) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wr_en(buf_we),
    .wr_addr(dbg_req.addr[4:0]),
    .wr_data(dbg_req.wdata),
    .rd_addr(st_reg.copy_idx[4:0]),
    .rd_data(buf_rdata)
  );

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  // One process decides every register; error and key-write clears come before sets so an event wins.
  always_comb
  begin
    st_next = st_reg;
    buf_we = 1'b0;
    cs_wr = cs_valid && cs_req.we;
    cs_rd = cs_valid && !cs_req.we;
    rst_release = cs_wr && (cs_req.addr == `PDI_OFS_RST) && (cs_req.wdata != `PDI_RST_SIGNATURE)
                  && (st_reg.rst_req == `PDI_RST_SIGNATURE);
    st_next.cs_ack = cs_valid;
    st_next.erase_start = 1'b0;
    st_next.dbg_done = 1'b0;
    st_next.dbg_refused = 1'b0;
    st_next.row_wr_en = 1'b0;

    // Synchronisers for pins and system-domain levels.
    st_next.rx_s1 = link_rx_pin;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.rx_s3 = st_reg.rx_s2;
    st_next.sleep_s1 = sys_sleep_async;
    st_next.sleep_s2 = st_reg.sleep_s1;
    st_next.stop_s1 = cpu_clk_stopped_async;
    st_next.stop_s2 = st_reg.stop_s1;
    st_next.lock = lockbits_set;
    // The event has no enable bit on purpose.
    st_next.sync_evt = sync_window && st_reg.rx_s2 && !st_reg.rx_s3;

    // Read multiplexer; unused offsets read as zero.
    rd_mux = 8'h00;
    unique case (cs_req.addr)
      `PDI_OFS_REV: rd_mux = REVISION;
      `PDI_OFS_ERR: rd_mux = {5'h00, st_reg.err};
      `PDI_OFS_CTRLP: rd_mux = st_reg.ctrl_p;
      `PDI_OFS_CTRLS: rd_mux = st_reg.ctrl_s;
      `PDI_OFS_KEY: rd_mux = 8'h00 | ({7'h00, st_reg.key_urow} << `PDI_BIT_KEY_UROW)
                             | ({7'h00, st_reg.key_nvm} << `PDI_BIT_KEY_NVM)
                             | ({7'h00, st_reg.key_erase} << `PDI_BIT_KEY_ERASE);
      `PDI_OFS_RST: rd_mux = {7'h00, st_reg.rst_req == `PDI_RST_SIGNATURE};
      `PDI_OFS_CLKSEL: rd_mux = {6'h00, st_reg.clk_sel};
      `PDI_OFS_SYSCTL: rd_mux = {7'h00, st_reg.keep_clk};
      `PDI_OFS_SYSSTAT: rd_mux = 8'h00 | ({7'h00, sys_reset_out} << `PDI_BIT_ST_RESET)
                                 | ({7'h00, st_reg.sleep_s2} << `PDI_BIT_ST_SLEEP)
                                 | ({7'h00, st_reg.nvm_state} << `PDI_BIT_ST_NVM)
                                 | ({7'h00, st_reg.urow_state} << `PDI_BIT_ST_UROW)
                                 | ({7'h00, st_reg.lock} << `PDI_BIT_ST_LOCK);
      `PDI_OFS_SCAN: rd_mux = {5'h00, scan_status};
      default: rd_mux = 8'h00;
    endcase
    // Only link requests reach this mux; there is no CPU-side port.
    st_next.cs_rdata = cs_rd ? rd_mux : 8'h00;

    // Error signature: cleared by a read, but a new error in that cycle is kept.
    if (cs_rd && cs_req.addr == `PDI_OFS_ERR)
    begin
      st_next.err = 3'h0;
    end
    if (phy_err_valid)
    begin
      st_next.err = phy_err_code;
    end

    // Register writes.
    if (cs_wr)
    begin
      unique case (cs_req.addr)
        `PDI_OFS_CTRLP: st_next.ctrl_p = cs_req.wdata & `PDI_MASK_CTRLP;
        `PDI_OFS_CTRLS: st_next.ctrl_s = cs_req.wdata & `PDI_MASK_CTRLS;
        `PDI_OFS_RST: st_next.rst_req = cs_req.wdata;
        `PDI_OFS_CLKSEL: st_next.clk_sel = cs_req.wdata[1:0];
        `PDI_OFS_KEY:
        begin
          // Writing the user-row key bit retires that key and its mode.
          if (cs_req.wdata[`PDI_BIT_KEY_UROW])
          begin
            st_next.key_urow = 1'b0;
            st_next.urow_state = 1'b0;
          end
        end
        `PDI_OFS_SYSCTL:
        begin
          st_next.keep_clk = cs_req.wdata[`PDI_BIT_CTL_KEEPCLK];
          if (cs_req.wdata[`PDI_BIT_CTL_UROWDONE] && st_reg.urow_state && !st_reg.copy_run)
          begin
            st_next.copy_run = 1'b1;
            st_next.copy_idx = 6'h00;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Keys arrive from the frame layer; an erase key leaves a program key alone.
    if (key_valid)
    begin
      unique case (key_kind)
        pdi_pkg::PDI_KEY_ERASE: st_next.key_erase = 1'b1;
        pdi_pkg::PDI_KEY_NVM: st_next.key_nvm = 1'b1;
        pdi_pkg::PDI_KEY_UROW: st_next.key_urow = 1'b1;
        pdi_pkg::PDI_KEY_NONE:
        begin
        end
      endcase
    end

    // Release of the system reset starts or ends the keyed sequences.
    if (rst_release)
    begin
      if (st_reg.key_erase && !st_reg.erase_run)
      begin
        st_next.erase_start = 1'b1;
        st_next.erase_run = 1'b1;
      end
      if (st_reg.key_nvm && !st_reg.lock)
      begin
        // The first pulse opens the session, the next one closes it.
        st_next.nvm_state = !st_reg.nvm_state;
        st_next.key_nvm = !st_reg.nvm_state;
      end
      if (st_reg.key_urow && st_reg.lock)
      begin
        st_next.urow_state = 1'b1;
      end
    end

    // Brownout detector held on with fuse level for the whole erase.
    if (st_reg.erase_run && erase_done)
    begin
      st_next.erase_run = 1'b0;
      st_next.key_erase = 1'b0;
    end
    st_next.bod_mode = st_next.erase_run ? `PDI_BOD_ACTIVE_ON : `PDI_BOD_ACTIVE_OFF;
    st_next.bod_level = bod_fuse_level;

    // Disabling the link drops every key and link setting.
    if (cs_wr && cs_req.addr == `PDI_OFS_CTRLS && cs_req.wdata[`PDI_BIT_DISABLE])
    begin
      st_next.key_erase = 1'b0;
      st_next.key_nvm = 1'b0;
      st_next.key_urow = 1'b0;
      st_next.ctrl_p = 8'h00;
      st_next.ctrl_s = 8'h00;
      st_next.clk_sel = `PDI_RST_CLKSEL;
    end

    // ***************************************************************
    // Debugger memory path
    // ***************************************************************
    // New requests are only looked at while no system access is open.
    if (st_reg.bus_wait)
    begin
      if (sys_ack)
      begin
        st_next.bus_wait = 1'b0;
        st_next.sys_req = 1'b0;
        st_next.dbg_done = 1'b1;
        st_next.dbg_rdata = st_reg.sys_bus.we ? 8'h00 : sys_rdata;
      end
    end
    else if (dbg_valid)
    begin
      st_next.dbg_rdata = 8'h00;
      if (st_reg.urow_state)
      begin
        // Reads and out-of-range writes give nothing back in this mode.
        if (dbg_req.we && dbg_req.addr < 16'(UROW_BYTES) && !st_reg.copy_run)
        begin
          buf_we = 1'b1;
          st_next.dbg_done = 1'b1;
        end
        else
        begin
          st_next.dbg_refused = 1'b1;
        end
      end
      else if (st_reg.lock)
      begin
        st_next.dbg_refused = 1'b1;
      end
      else if (st_reg.stop_s2 && !st_reg.keep_clk)
      begin
        st_next.dbg_refused = 1'b1;
      end
      else
      begin
        // With keep-clock set the system clock still runs, so access goes on.
        st_next.sys_req = 1'b1;
        st_next.sys_bus = dbg_req;
        st_next.bus_wait = 1'b1;
      end
    end

    // ***************************************************************
    // Row copy
    // ***************************************************************
    // Read index k, write byte k one cycle later at the same row position.
    st_next.copy_pend = 1'b0;
    if (st_reg.copy_run)
    begin
      if (st_reg.copy_idx < 6'(UROW_BYTES))
      begin
        st_next.copy_pend = 1'b1;
        st_next.copy_pidx = st_reg.copy_idx[4:0];
        st_next.copy_idx = st_reg.copy_idx + 6'h01;
      end
      else if (!st_reg.copy_pend)
      begin
        st_next.copy_run = 1'b0;
        st_next.urow_state = 1'b0;
      end
    end
    if (st_reg.copy_pend)
    begin
      st_next.row_wr_en = 1'b1;
      st_next.row_addr = st_reg.copy_pidx;
      st_next.row_data = buf_rdata;
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // The system reset we drive never reaches this process; only resetn does.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
      st_reg.clk_sel <= `PDI_RST_CLKSEL;
      st_reg.keep_clk <= `PDI_RST_KEEPCLK;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Link-side logic uses the sleep input only for the asleep status flag, so it runs through every sleep mode.
  assign cs_ack = st_reg.cs_ack;
  assign cs_rdata = st_reg.cs_rdata;
  assign phy_ctrl_primary = st_reg.ctrl_p;
  assign phy_ctrl_secondary = st_reg.ctrl_s;
  assign access_clk_sel = st_reg.clk_sel;
  assign sync_edge_event = st_reg.sync_evt;
  assign sys_reset_out = st_reg.rst_req == `PDI_RST_SIGNATURE;
  assign erase_start = st_reg.erase_start;
  assign bod_force_on = st_reg.erase_run;
  assign bod_active_mode = st_reg.bod_mode;
  assign bod_level = st_reg.bod_level;
  assign keep_clock_out = st_reg.keep_clk;
  assign dbg_done = st_reg.dbg_done;
  assign dbg_refused = st_reg.dbg_refused;
  assign dbg_rdata = st_reg.dbg_rdata;
  assign sys_req = st_reg.sys_req;
  assign sys_bus = st_reg.sys_bus;
  assign row_wr_en = st_reg.row_wr_en;
  assign row_addr = st_reg.row_addr;
  assign row_data = st_reg.row_data;
endmodule
`default_nettype wire

// ---- dv/pdi_access_monitor.sv ----
// Purpose: Port assertions of the access block.
// Assumes: Bound to pdi_access; one clock.
// Notes: Delays follow the port contract.
`timescale 1ns/100ps
`default_nettype none
module pdi_access_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_valid,
  input wire pdi_pkg::pdi_cs_req_t cs_req,
  input wire logic cs_ack,
  input wire logic link_rx_pin,
  input wire logic sync_window,
  input wire logic sync_edge_event,
  input wire logic lockbits_set,
  input wire logic [2:0] bod_fuse_level,
  input wire logic sys_reset_out,
  input wire logic erase_start,
  input wire logic bod_force_on,
  input wire logic [1:0] bod_active_mode,
  input wire logic [2:0] bod_level,
  input wire logic keep_clock_out,
  input wire logic sys_req,
  input wire logic row_wr_en,
  input wire logic [4:0] row_addr
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic wr8;
  // A write to the reset request slot.
  assign wr8 = cs_valid && cs_req.we && cs_req.addr == 4'h8;
  property p_rst_set; wr8 && cs_req.wdata == 8'h59 |=> sys_reset_out; endproperty
  a_rst_set: assert property (p_rst_set) else $error("reset not raised");
  property p_rst_clr; wr8 && cs_req.wdata != 8'h59 |=> !sys_reset_out; endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("reset not released");
  property p_ack; cs_valid |=> cs_ack; endproperty
  a_ack: assert property (p_ack) else $error("no register answer");
  property p_bod; bod_active_mode == (bod_force_on ? 2'h1 : 2'h0); endproperty
  a_bod: assert property (p_bod) else $error("brownout mode wrong");
  property p_lvl; $past(resetn) |-> bod_level == $past(bod_fuse_level); endproperty
  a_lvl: assert property (p_lvl) else $error("brownout level wrong");
  property p_sync; $rose(link_rx_pin) && sync_window |-> ##[1:4] (sync_edge_event || !sync_window); endproperty
  a_sync: assert property (p_sync) else $error("sync event missing");
  property p_keep; cs_valid && cs_req.we && cs_req.addr == 4'hA |=> keep_clock_out == $past(cs_req.wdata[0]); endproperty
  a_keep: assert property (p_keep) else $error("keep clock wrong");
  property p_lock; $rose(sys_req) |-> !$past(lockbits_set, 2); endproperty
  a_lock: assert property (p_lock) else $error("locked bus access");
  property p_row; row_wr_en && row_addr != 5'h1F |=> row_wr_en && row_addr == $past(row_addr) + 5'h1; endproperty
  a_row: assert property (p_row) else $error("row copy order wrong");
  c_erase: cover property (erase_start);
  c_sync: cover property (sync_edge_event);
  c_row: cover property (row_wr_en && row_addr == 5'h1F);
endmodule
bind pdi_access pdi_access_monitor u_mon (.ref_clk, .resetn, .cs_valid, .cs_req, .cs_ack, .link_rx_pin,
  .sync_window, .sync_edge_event, .lockbits_set, .bod_fuse_level, .sys_reset_out, .erase_start,
  .bod_force_on, .bod_active_mode, .bod_level, .keep_clock_out, .sys_req, .row_wr_en, .row_addr);
`default_nettype wire

// ---- dv/pdi_sys_model.sv ----
// Purpose: System side model: memory and erase engine.
// Assumes: Requests held until acknowledged.
// Notes: Idle read data toggles, so stale bytes stand out.
`timescale 1ns/100ps
`default_nettype none
module pdi_sys_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic sys_req,
  input wire pdi_pkg::pdi_bus_req_t sys_bus,
  input wire logic erase_start,
  output logic sys_ack,
  output logic [7:0] sys_rdata,
  output logic erase_done
);
  logic [7:0] mem [0:255];
  logic [3:0] wcnt;
  logic [4:0] ecnt;
  // ****************
  // Responder
  // ****************
  // Answers after one or five cycles; an erase takes twenty.
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sys_ack <= 1'b0;
      sys_rdata <= 8'h00;
      wcnt <= 4'h0;
      ecnt <= 5'h0;
      erase_done <= 1'b0;
    end
    else
    begin
      erase_done <= ecnt == 5'h1;
      ecnt <= erase_start ? 5'h14 : (ecnt != 5'h0 ? ecnt - 5'h1 : ecnt);
      sys_ack <= 1'b0;
      sys_rdata <= ~sys_rdata;
      if (sys_req && !sys_ack)
      begin
        wcnt <= wcnt + 4'h1;
        if (wcnt >= (slow ? 4'h4 : 4'h0))
        begin
          wcnt <= 4'h0;
          sys_ack <= 1'b1;
          sys_rdata <= mem[sys_bus.addr[7:0]];
          if (sys_bus.we)
            mem[sys_bus.addr[7:0]] <= sys_bus.wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/pdi_access_tb.sv ----
// Purpose: Bench for the debug access block.
// Assumes: Bench plays link and lock bits.
// Notes: Drivers queue notes; a watcher matches them.
`timescale 1ns/100ps
`default_nettype none
`include "pdi_access_consts.svh"
module pdi_access_tb;
  logic ref_clk = 1'b0, resetn = 1'b0, cs_valid = 1'b0, key_valid = 1'b0, phy_err_valid = 1'b0;
  logic link_rx_pin = 1'b0, sync_window = 1'b0, sys_sleep_async = 1'b0, cpu_clk_stopped_async = 1'b0;
  logic lockbits_set = 1'b1, dbg_valid = 1'b0, slow = 1'b0;
  logic [2:0] phy_err_code = 3'h0, scan_status = 3'h5, bod_fuse_level = 3'h3;
  pdi_pkg::pdi_cs_req_t cs_req = '0;
  pdi_pkg::pdi_key_t key_kind = pdi_pkg::PDI_KEY_NONE;
  pdi_pkg::pdi_bus_req_t dbg_req = '0, sys_bus;
  logic cs_ack, dbg_done, dbg_refused, sys_req, sys_ack, erase_start, erase_done, row_wr_en, sync_edge_event;
  logic [7:0] cs_rdata, dbg_rdata, sys_rdata, row_data, rd, v;
  logic [4:0] row_addr;
  logic [17:0] q[$];
  integer seed = 17627;
  int n_fail = 0, checks_done = 0, cyc = 0, nrow = 0, nevt = 0;
  // ****************
  // Structure
  // ****************
  always #20 ref_clk = ~ref_clk;
  pdi_access dut (.ref_clk, .resetn, .cs_valid, .cs_req, .cs_ack, .cs_rdata, .key_valid, .key_kind,
    .phy_err_valid, .phy_err_code, .phy_ctrl_primary(), .phy_ctrl_secondary(), .access_clk_sel(),
    .link_rx_pin, .sync_window, .sync_edge_event, .sys_sleep_async, .cpu_clk_stopped_async, .lockbits_set,
    .erase_done, .scan_status, .bod_fuse_level, .sys_reset_out(), .erase_start, .bod_force_on(),
    .bod_active_mode(), .bod_level(), .keep_clock_out(), .dbg_valid, .dbg_req, .dbg_done, .dbg_refused,
    .dbg_rdata, .sys_req, .sys_bus, .sys_ack, .sys_rdata, .row_wr_en, .row_addr, .row_data);
  pdi_sys_model u_sys (.ref_clk, .resetn, .slow, .sys_req, .sys_bus, .erase_start, .sys_ack, .sys_rdata,
    .erase_done);
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [8:0] got, input logic [17:0] e);
    checks_done++;
    if ((got & e[17:9]) !== e[8:0])
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e[8:0]);
    end
  endtask
  task automatic cs(input logic we, input logic [3:0] a, input logic [7:0] d, input logic [7:0] m, input logic [7:0] x);
    q.push_back({1'b1, m, 1'b0, x});
    @(posedge ref_clk);
    cs_valid <= 1'b1;
    cs_req <= '{we, a, d};
    @(posedge ref_clk);
    cs_valid <= 1'b0;
    @(negedge ref_clk);
    rd = cs_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cs(1'b1, a, d, 8'hFF, 8'h00);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    cs(1'b0, a, 8'h00, m, x);
  endtask
  // A refusal is masked in so its data byte is ignored.
  task automatic dbg(input logic we, input logic [15:0] a, input logic [7:0] d, input logic [8:0] m, input logic [8:0] x);
    q.push_back({m, x});
    @(posedge ref_clk);
    dbg_valid <= 1'b1;
    dbg_req <= '{we, a, d};
    @(posedge ref_clk);
    dbg_valid <= 1'b0;
    for (int i = 0; i < 30 && dbg_done !== 1'b1 && dbg_refused !== 1'b1; i++)
      @(negedge ref_clk);
  endtask
  task automatic poll(input logic [3:0] a, input int b, input logic w);
    // Spoil the last byte so the first pass always reads afresh.
    rd = {8{!w}};
    for (int i = 0; i < 100 && rd[b] !== w; i++)
      rdx(a, 8'h00, 8'h00);
    rdx(a, 8'h01 << b, {7'h0, w} << b);
  endtask
  task automatic key(input pdi_pkg::pdi_key_t k);
    @(posedge ref_clk);
    key_valid <= 1'b1;
    key_kind <= k;
    @(posedge ref_clk);
    key_valid <= 1'b0;
  endtask
  task automatic pulse_rst;
    wr(4'h8, `PDI_RST_SIGNATURE);
    wr(4'h8, 8'h00);
  endtask
  task automatic wrap_up;
    if (q.size() != 0)
      n_fail++;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watcher: checks answers in order; plays the lock bits.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
    if (cs_ack === 1'b1)
      chk({1'b0, cs_rdata}, q.pop_front());
    if (dbg_done === 1'b1 || dbg_refused === 1'b1)
      chk({dbg_refused, dbg_rdata}, q.pop_front());
    if (row_wr_en === 1'b1)
      nrow++;
    if (row_wr_en === 1'b1 && row_addr === 5'h05)
      chk({1'b0, row_data}, {9'h0FF, 1'b0, v});
    if (sync_edge_event === 1'b1)
      nevt++;
    if (erase_done === 1'b1)
      lockbits_set <= 1'b0;
  end
  // Main sequence: map, erase, programming, sleep, row, sync.
  initial
  begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    rdx(4'h0, 8'hFF, `PDI_RST_REV);
    wr(4'h0, 8'hFF);
    rdx(4'h0, 8'hFF, `PDI_RST_REV);
    rdx(4'hA, 8'hFF, 8'h01);
    rdx(4'h5, 8'hFF, 8'h00);
    rdx(4'hD, 8'hFF, 8'h00);
    v = $random(seed);
    wr(4'h2, v);
    rdx(4'h2, 8'hFF, v & `PDI_MASK_CTRLP);
    @(posedge ref_clk);
    phy_err_valid <= 1'b1;
    phy_err_code <= 3'h3;
    @(posedge ref_clk);
    phy_err_valid <= 1'b0;
    rdx(4'h1, 8'hFF, 8'h03);
    rdx(4'h1, 8'hFF, 8'h00);
    dbg(1'b1, 16'h0010, 8'hAA, 9'h100, 9'h100);
    key(pdi_pkg::PDI_KEY_ERASE);
    rdx(4'h7, 8'hFF, 8'h08);
    wr(4'h8, `PDI_RST_SIGNATURE);
    rdx(4'h8, 8'hFF, 8'h01);
    rdx(4'hB, 8'h21, 8'h21);
    wr(4'h8, 8'h00);
    rdx(4'h8, 8'hFF, 8'h00);
    poll(4'hB, 0, 1'b0);
    rdx(4'h7, 8'hFF, 8'h00);
    key(pdi_pkg::PDI_KEY_NVM);
    pulse_rst();
    poll(4'hB, 3, 1'b1);
    slow <= 1'b1;
    v = $random(seed);
    dbg(1'b1, 16'h0040, v, 9'h1FF, 9'h000);
    dbg(1'b0, 16'h0040, 8'h00, 9'h1FF, {1'b0, v});
    pulse_rst();
    rdx(4'hB, 8'h08, 8'h00);
    sys_sleep_async <= 1'b1;
    cpu_clk_stopped_async <= 1'b1;
    poll(4'hB, 4, 1'b1);
    dbg(1'b0, 16'h0040, 8'h00, 9'h1FF, {1'b0, v});
    wr(4'hA, 8'h00);
    dbg(1'b0, 16'h0040, 8'h00, 9'h100, 9'h100);
    sys_sleep_async <= 1'b0;
    cpu_clk_stopped_async <= 1'b0;
    lockbits_set <= 1'b1;
    key(pdi_pkg::PDI_KEY_UROW);
    pulse_rst();
    poll(4'hB, 2, 1'b1);
    v = $random(seed);
    dbg(1'b1, 16'h0005, v, 9'h1FF, 9'h000);
    dbg(1'b1, 16'h0020, 8'h11, 9'h100, 9'h100);
    dbg(1'b0, 16'h0005, 8'h00, 9'h100, 9'h100);
    nrow = 0;
    wr(4'hA, 8'h03);
    poll(4'hB, 2, 1'b0);
    chk({1'b0, nrow[7:0]}, {9'h0FF, 9'h020});
    wr(4'h7, 8'h20);
    rdx(4'h7, 8'h20, 8'h00);
    sync_window <= 1'b1;
    repeat (3)
    begin
      link_rx_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      link_rx_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
    sync_window <= 1'b0;
    chk(nevt[8:0], {9'h1FF, 9'h003});
    wrap_up();
  end
endmodule
`default_nettype wire
